// ===== dv/isa_host_model.sv
// ISA host model issuing byte-wide I/O write and read cycles
module isa_host_model (
  input  wire logic       clock_i,  // Bus timing clock
  input  wire logic [7:0] sd_o,     // Read data from device
  input  wire logic       sd_oe_o,  // Device drives data bus
  output logic      [9:0] sa_i,     // Address A9..A0
  output logic            aen_i,    // DMA address enable
  output logic            iow_n_i,  // Write strobe, low active
  output logic            ior_n_i,  // Read strobe, low active
  output logic      [7:0] sd_i      // Write data
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero
  initial begin
    sa_i = 10'h000;
    aen_i = 1'b0;
    iow_n_i = 1'b1;
    ior_n_i = 1'b1;
    sd_i = 8'h00;
  end
  // Strobe low 4 clocks, address and data held 4 clocks past it
  task automatic io_write(input logic [9:0] a, input logic [7:0] d, input logic dma);
    @(posedge clock_i);
    sa_i <= a;
    sd_i <= d;
    aen_i <= dma;
    iow_n_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    iow_n_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    sd_i <= ~d;
    aen_i <= 1'b0;
    repeat (2) @(posedge clock_i);
  endtask
  // Strobe low 6 clocks, data taken at the same edge that releases it
  task automatic io_read(input logic [9:0] a, output logic [7:0] d, output logic oe);
    @(posedge clock_i);
    sa_i <= a;
    ior_n_i <= 1'b0;
    repeat (6) @(posedge clock_i);
    d = sd_o;
    oe = sd_oe_o;
    ior_n_i <= 1'b1;
    repeat (6) @(posedge clock_i);
  endtask
endmodule // isa_host_model

// ===== dv/tb_relay_input_port.sv
// Testbench: relay writes, read-back, input reads and refused cycles
module tb_relay_input_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock_i;   // 20 MHz clock
  logic       rst_n_i;   // Reset, active low
  logic [7:0] iso_in_i;  // Isolated inputs
  logic [9:0] sa_i;
  logic       aen_i, iow_n_i, ior_n_i, sd_oe_o;
  logic [7:0] sd_i, sd_o, relay_o, rd_d;
  logic       rd_oe;
  int         n_fail, checks;
  // Write table: address, data, dma flag, relay byte expected after; base 2a8 in window
  localparam logic [9:0] WA [8] = '{10'h2a8, 10'h2a8, 10'h2a9, 10'h0a8,
                                    10'h2aa, 10'h3a8, 10'h2a8, 10'h2a8};
  localparam logic [7:0] WD [8] = '{8'h81, 8'h01, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h80};
  localparam logic       WE [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  localparam logic [7:0] WX [8] = '{8'h81, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h80};
  // Read table: address, drive expected, data expected
  localparam logic [9:0] RA [4] = '{10'h2a8, 10'h2a9, 10'h2ab, 10'h0a9};
  localparam logic       RO [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  localparam logic [7:0] RX [4] = '{8'h80, 8'h3a, 8'h00, 8'h00};
  relay_input_port uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .sa_i(sa_i), .aen_i(aen_i),
    .iow_n_i(iow_n_i), .ior_n_i(ior_n_i), .sd_i(sd_i), .iso_in_i(iso_in_i), .sd_o(sd_o),
    .sd_oe_o(sd_oe_o), .relay_o(relay_o));
  isa_host_model host (.clock_i(clock_i), .sd_o(sd_o), .sd_oe_o(sd_oe_o), .sa_i(sa_i),
    .aen_i(aen_i), .iow_n_i(iow_n_i), .ior_n_i(ior_n_i), .sd_i(sd_i));
  // Clock generator
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  // Compare and count
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic end_sim;
    if (n_fail == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #200us;
    n_fail++;
    end_sim();
  end
  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    iso_in_i = 8'h00;
    repeat (6) @(posedge clock_i);
    chk("relay_reset", relay_o, 8'h00);
    rst_n_i <= 1'b1;
    iso_in_i <= 8'h3a;
    repeat (4) @(posedge clock_i);
    for (int i = 0; i < 8; i++) begin
      host.io_write(WA[i], WD[i], WE[i]);
      chk("relay_o", relay_o, WX[i]);
    end
    for (int i = 0; i < 4; i++) begin
      host.io_read(RA[i], rd_d, rd_oe);
      chk("sd_oe_o", {7'h00, rd_oe}, {7'h00, RO[i]});
      chk("sd_o", rd_d, RX[i]);
    end
    // Reset in mid-run clears relays that were set
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    chk("relay_midreset", relay_o, 8'h00);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    host.io_read(10'h2a8, rd_d, rd_oe);
    chk("sd_oe_o", {7'h00, rd_oe}, 8'h01);
    chk("sd_o", rd_d, 8'h00);
    end_sim();
  end
endmodule // tb_relay_input_port

// ===== rtl/isa_addr_decoder.sv
// Module: combinational base address compare against the address select switch
module isa_addr_decoder (
  input  wire logic [9:0]   addr_i,    // Synchronised address lines A9..A0
  input  wire logic         aen_i,     // DMA address enable (high blocks I/O decode)
  input  wire logic [7:0]   switch_i,  // Position 1..8 in bits 7..0, 1 = ON
  port_sel_if.decoder       sel
);
  logic [7:0] base_bits;  // Address bits A8..A1 selected by the switch

  // Position k maps to A(9-k); ON means address bit zero
  always_comb begin
    base_bits = ~switch_i;
    sel.offset = addr_i[0];
    sel.hit = !aen_i && (addr_i[9] == relay_port_pkg::BASE_A9)
              && (addr_i[8:1] == base_bits);
  end
endmodule // isa_addr_decoder

// ===== rtl/port_sel_if.sv
// Interface: decoded port select from the address decoder to the register core
interface port_sel_if;
  logic hit;     // Cycle addresses one of the two ports
  logic offset;  // Which port of the pair
  modport decoder (output hit, output offset);
  modport core    (input  hit, input  offset);
endinterface : port_sel_if

// ===== rtl/relay_input_port.sv
// Module: eight relay outputs and eight isolated inputs on two ISA I/O ports
//
// Behaviour
// - Answer only two consecutive ports at base
// - Switch positions one..eight match A8..A1
// - Base has A0 zero, A9 one
// - Default switch gives base 2a8h
// - Offset 0 relays, offset 1 inputs
// - Write offset 0 latches relay byte
// - Bit n drives relay n
// - Read offset 0 returns latched relays
// - Read offset 1 returns all inputs
// - Input bit n is channel n
// - Reset releases every relay
module relay_input_port #(
  parameter logic [7:0] SWITCH_SETTING = relay_port_pkg::SWITCH_DEFAULT
) (
  input  wire logic         clock_i,        // 20 MHz system clock
  input  wire logic         rst_n_i,        // Asynchronous reset, active low
  input  wire logic [9:0]   sa_i,           // ISA address A9..A0
  input  wire logic         aen_i,          // ISA address enable
  input  wire logic         iow_n_i,        // ISA I/O write strobe, low active
  input  wire logic         ior_n_i,        // ISA I/O read strobe, low active
  input  wire logic [7:0]   sd_i,           // ISA data from host
  input  wire logic [7:0]   iso_in_i,       // Isolated input channels 0..7
  output logic      [7:0]   sd_o,           // ISA data to host
  output logic              sd_oe_o,        // ISA data drive enable
  output logic      [7:0]   relay_o         // Relay coil drives 0..7
);
  // Two-stage synchronisers for all pin inputs
  logic [9:0] sa_s1_reg,  sa_s2_reg;
  logic [7:0] sd_s1_reg,  sd_s2_reg;
  logic [7:0] in_s1_reg,  in_s2_reg;
  logic       aen_s1_reg, aen_s2_reg;
  logic       iow_s1_reg, iow_s2_reg;   // Active-high write strobe
  logic       ior_s1_reg, ior_s2_reg;   // Active-high read strobe
  logic       iow_d_reg;                // Previous write strobe for edge detect

  // Register state
  logic [7:0] relay_reg,  relay_next;   // Latched relay drive byte
  logic [7:0] sd_reg,     sd_next;      // Read data driven to bus
  logic       oe_reg,     oe_next;      // Bus drive enable
  logic       iow_d_next;

  // Decoder output, combinational off synchronised address lines
  port_sel_if sel ();                   // Decoded select

  // Switch setting is fixed at build time; no register holds it
  // Address compare against switch bits
  isa_addr_decoder u_dec (
    .addr_i   (sa_s2_reg),
    .aen_i    (aen_s2_reg),
    .switch_i (SWITCH_SETTING),
    .sel      (sel.decoder)
  );

  // Strobes are inverted on entry so the rest of the block is active high
  // Address, data and strobes share the same depth, so they stay aligned
  // Synchronisers; first stage only feeds the second
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sa_s1_reg  <= '0;
      sa_s2_reg  <= '0;
      sd_s1_reg  <= '0;
      sd_s2_reg  <= '0;
      in_s1_reg  <= relay_port_pkg::INPUT_RESET;
      in_s2_reg  <= relay_port_pkg::INPUT_RESET;
      aen_s1_reg <= 1'b1;
      aen_s2_reg <= 1'b1;
      iow_s1_reg <= 1'b0;
      iow_s2_reg <= 1'b0;
      ior_s1_reg <= 1'b0;
      ior_s2_reg <= 1'b0;
    end else begin
      sa_s1_reg  <= sa_i;
      sa_s2_reg  <= sa_s1_reg;
      sd_s1_reg  <= sd_i;
      sd_s2_reg  <= sd_s1_reg;
      in_s1_reg  <= iso_in_i;
      in_s2_reg  <= in_s1_reg;
      aen_s1_reg <= aen_i;
      aen_s2_reg <= aen_s1_reg;
      iow_s1_reg <= !iow_n_i;
      iow_s2_reg <= iow_s1_reg;
      ior_s1_reg <= !ior_n_i;
      ior_s2_reg <= ior_s1_reg;
    end
  end

  // Next-state for relays and read path
  always_comb begin
    // Defaults: relays hold, bus released, read data zero
    relay_next = relay_reg;
    iow_d_next = iow_s2_reg;
    sd_next    = '0;
    oe_next    = 1'b0;
    // Latch on the trailing edge of the write strobe, data is stable there
    // Address and data sit two stages behind their pins, same as the strobe
    if (iow_d_reg && !iow_s2_reg && sel.hit) begin
      if (sel.offset == relay_port_pkg::OFFSET_RELAY) begin
        relay_next = sd_s2_reg;
      end
      // Writes to the input port do nothing
    end
    // Drive the bus only while a decoded read is active
    // Relay port answers with the latch, input port with synchronised inputs
    if (ior_s2_reg && sel.hit) begin
      oe_next = 1'b1;
      if (sel.offset == relay_port_pkg::OFFSET_RELAY) begin
        sd_next = relay_reg;
      end else begin
        sd_next = in_s2_reg;
      end
    end
  end

  // Register stage; reset releases every relay
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      relay_reg <= relay_port_pkg::RELAY_RESET;
      sd_reg    <= '0;
      oe_reg    <= 1'b0;
      // Edge detector starts at the idle level, so reset makes no false edge
      iow_d_reg <= 1'b0;
    end else begin
      relay_reg <= relay_next;
      sd_reg    <= sd_next;
      oe_reg    <= oe_next;
      iow_d_reg <= iow_d_next;
    end
  end

  // Outputs come straight from their flip-flops
  assign relay_o = relay_reg;
  assign sd_o    = sd_reg;
  assign sd_oe_o = oe_reg;

  // Checks: one clock domain, all quiet while reset is held
  // Properties see the synchronised strobes, as the logic does
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // Write strobe high, then low on a decoded relay-port cycle
  sequence write_relay_s;
    iow_s2_reg ##1 (!iow_s2_reg && sel.hit && !sel.offset);
  endsequence

  // Write strobe high, then low on a decoded input-port cycle
  sequence write_input_s;
    iow_s2_reg ##1 (!iow_s2_reg && sel.hit && sel.offset);
  endsequence

  // Read strobe held on a decoded relay-port cycle
  sequence read_relay_s;
    ior_s2_reg && sel.hit && !sel.offset;
  endsequence

  // Read strobe held on a decoded input-port cycle
  sequence read_input_s;
    ior_s2_reg && sel.hit && sel.offset;
  endsequence

  // Write to the relay port lands one edge later
  relay_latch_a: assert property (write_relay_s |=> relay_o == $past(sd_s2_reg))
    else $error("relay byte not latched");

  // Without a relay-port write the relay byte holds
  relay_hold_a: assert property (
      !(iow_d_reg && !iow_s2_reg && sel.hit && !sel.offset) |=> $stable(relay_o))
    else $error("relay byte changed without write");

  // A write aimed at the input port leaves the relays alone
  input_write_a: assert property (write_input_s |=> $stable(relay_o))
    else $error("write to input port changed relays");

  // Relay port read returns the latched byte
  read_relay_a: assert property (
      read_relay_s |=> sd_oe_o && sd_o == $past(relay_reg))
    else $error("relay read-back wrong");

  // Input port read returns all eight inputs, bit for bit
  read_input_a: assert property (
      read_input_s |=> sd_oe_o && sd_o == $past(in_s2_reg))
    else $error("input read wrong");

  // No decoded read, no bus drive
  bus_release_a: assert property (!(ior_s2_reg && sel.hit) |=> !sd_oe_o)
    else $error("bus driven outside decoded read");

  // Released bus carries zero, never stale data
  idle_zero_a: assert property (!sd_oe_o |-> sd_o == 8'h00)
    else $error("data present while bus released");

  // Drive only follows a read strobe seen one edge before
  drive_cause_a: assert property (sd_oe_o |-> $past(ior_s2_reg))
    else $error("bus driven without read strobe");

  // Hit only on the switch address with A9 set and no DMA cycle
  decode_range_a: assert property (
      sel.hit |-> sa_s2_reg[9] && !aen_s2_reg && sa_s2_reg[8:1] == ~SWITCH_SETTING)
    else $error("decode hit at wrong address");

  // Every non-DMA cycle to the own pair is answered
  decode_miss_a: assert property (
      (!aen_s2_reg && sa_s2_reg[9:1] == {1'b1, ~SWITCH_SETTING}) |-> sel.hit)
    else $error("decode missed own address");

  // DMA cycles never decode
  dma_block_a: assert property (aen_s2_reg |-> !sel.hit)
    else $error("decode hit during DMA cycle");

  // Hits stay inside the upper half of the port space
  port_window_a: assert property (sel.hit |-> sa_s2_reg >= relay_port_pkg::WINDOW_LO)
    else $error("decode hit below port window");

  // Factory switch setting decodes the factory port pair
  default_base_a: assert property (
      sel.hit && SWITCH_SETTING == relay_port_pkg::SWITCH_DEFAULT
      |-> sa_s2_reg[9:1] == relay_port_pkg::DEFAULT_BASE[9:1])
    else $error("factory setting decodes wrong pair");
endmodule // relay_input_port

// ===== rtl/relay_port_pkg.sv
// Package: address decode constants, register offsets and reset values of the relay/input port
package relay_port_pkg;
  localparam int unsigned   ADDR_W         = 10;        // ISA I/O address bits used
  localparam int unsigned   DATA_W         = 8;         // Byte-wide data path
  localparam int unsigned   SWITCH_W       = 8;         // Address select switch positions
  localparam logic [9:0]    WINDOW_LO      = 10'h200;   // Lowest legal base
  localparam logic [9:0]    WINDOW_HI      = 10'h3ff;   // Highest legal port
  localparam logic          BASE_A9        = 1'b1;      // Fixed address bit 9
  localparam logic          BASE_A0        = 1'b0;      // Fixed address bit 0
  localparam logic [7:0]    SWITCH_DEFAULT = 8'hab;     // Positions 1..8 in bits 7..0, ON = 1
  localparam logic [9:0]    DEFAULT_BASE   = 10'h2a8;   // Factory base address
  localparam logic          OFFSET_RELAY   = 1'b0;      // Relay drive and read-back
  localparam logic          OFFSET_INPUT   = 1'b1;      // Isolated input states
  localparam logic [7:0]    RELAY_RESET    = 8'h00;     // All relays released
  localparam logic [7:0]    INPUT_RESET    = 8'h00;     // Input sampler reset value
endpackage : relay_port_pkg
